//--- inc/tma_pkg.sv
// Purpose: Shared constants for the temperature monitor register and alarm block
// Assumes: 50 MHz system clock
// Notes: Read and write addresses differ for several registers
package tma_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned TMA_CLK_HZ = 50_000_000;
   localparam int unsigned TMA_TIMEOUT_MS = 25;
   localparam int unsigned TMA_TIMEOUT_CYCLES = TMA_CLK_HZ / 1000 * TMA_TIMEOUT_MS;
   // Period between conversion cycles at the fastest rate code
   localparam int unsigned TMA_FAST_CONV_US = 31250;
   localparam int unsigned TMA_FAST_CONV_CYCLES = TMA_CLK_HZ / 1_000_000 * TMA_FAST_CONV_US;

   // ------------------------------------------------------------
   // Read addresses
   // ------------------------------------------------------------
   localparam logic [7:0] TMA_RD_LOCAL_VAL = 8'h00;
   localparam logic [7:0] TMA_RD_REMOTE_HI = 8'h01;
   localparam logic [7:0] TMA_RD_STATUS = 8'h02;
   localparam logic [7:0] TMA_RD_CONFIG = 8'h03;
   localparam logic [7:0] TMA_RD_RATE = 8'h04;
   localparam logic [7:0] TMA_RD_LOC_HLIM = 8'h05;
   localparam logic [7:0] TMA_RD_LOC_LLIM = 8'h06;
   localparam logic [7:0] TMA_RD_REM_HLIM_HI = 8'h07;
   localparam logic [7:0] TMA_RD_REM_LLIM_HI = 8'h08;
   localparam logic [7:0] TMA_RD_REMOTE_LO = 8'h10;
   localparam logic [7:0] TMA_RD_MAKER = 8'hFE;
   localparam logic [7:0] TMA_RD_REVISION = 8'hFF;

   // ------------------------------------------------------------
   // Write addresses (same-address registers share one constant)
   // ------------------------------------------------------------
   localparam logic [7:0] TMA_WR_CONFIG = 8'h09;
   localparam logic [7:0] TMA_WR_RATE = 8'h0A;
   localparam logic [7:0] TMA_WR_LOC_HLIM = 8'h0B;
   localparam logic [7:0] TMA_WR_LOC_LLIM = 8'h0C;
   localparam logic [7:0] TMA_WR_REM_HLIM_HI = 8'h0D;
   localparam logic [7:0] TMA_WR_REM_LLIM_HI = 8'h0E;
   localparam logic [7:0] TMA_WR_ONESHOT = 8'h0F;
   localparam logic [7:0] TMA_RW_OFFSET_HI = 8'h11;
   localparam logic [7:0] TMA_RW_OFFSET_LO = 8'h12;
   localparam logic [7:0] TMA_RW_REM_HLIM_LO = 8'h13;
   localparam logic [7:0] TMA_RW_REM_LLIM_LO = 8'h14;
   localparam logic [7:0] TMA_RW_REM_TRIP = 8'h19;
   localparam logic [7:0] TMA_RW_LOC_TRIP = 8'h20;
   localparam logic [7:0] TMA_RW_HYST = 8'h21;
   localparam logic [7:0] TMA_RW_FILTER = 8'h22;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] TMA_RST_ZERO = 8'h00;
   localparam logic [7:0] TMA_RST_RATE = 8'h08;
   localparam logic [7:0] TMA_RST_HLIM = 8'h55;
   localparam logic [7:0] TMA_RST_TRIP = 8'h55;
   localparam logic [7:0] TMA_RST_HYST = 8'h0A;
   localparam logic [7:0] TMA_RST_FILTER = 8'h01;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int TMA_ST_BUSY = 7;
   localparam int TMA_ST_LOC_OVER = 6;
   localparam int TMA_ST_LOC_UNDER = 5;
   localparam int TMA_ST_REM_OVER = 4;
   localparam int TMA_ST_REM_UNDER = 3;
   localparam int TMA_ST_OPEN = 2;
   localparam int TMA_ST_REM_TRIP = 1;
   localparam int TMA_ST_LOC_TRIP = 0;
   localparam int TMA_CFG_MASK = 7;
   localparam int TMA_CFG_STANDBY = 6;
   localparam int TMA_FLT_TIMEOUT = 7;
   localparam int TMA_FLT_CNT_LSB = 1;
   localparam logic [3:0] TMA_RATE_MAX = 4'h9;

   // Filter field 000/001/011/111 -> 1..4 results needed
   function automatic logic [2:0] tma_filter_need(input logic [2:0] f);
      return 3'(3'd1 + 3'(f[0]) + 3'(f[1]) + 3'(f[2]));
   endfunction

endpackage

//--- rtl/tma_conv_sched.sv
// Purpose: Conversion scheduler: rate divider, standby, one-shot, busy
// Assumes: converter answers each adc_start with one adc_done pulse
// Notes: a cycle in progress finishes even if standby is set
`timescale 1ns/10ps
`default_nettype none
module tma_conv_sched
   import tma_pkg::*;
#(
   parameter int unsigned BASE_CYCLES = TMA_FAST_CONV_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic standby,
   input wire logic oneshot,
   input wire logic [3:0] rate_code,
   input wire logic adc_done,
   output logic adc_start,
   output logic adc_remote,
   output logic busy
);

   typedef enum logic [1:0] {IDLE, LOCAL, REMOTE} tma_conv_type;
   tma_conv_type state_r;
   logic [31:0] wait_r;
   logic [3:0] code;
   logic [31:0] period;
   logic go;

   // Reserved codes behave as the fastest rate
   assign code = (rate_code > TMA_RATE_MAX) ? TMA_RATE_MAX : rate_code;
   assign period = 32'(BASE_CYCLES) << (TMA_RATE_MAX - code);
   assign go = (state_r == IDLE) && (standby ? oneshot : (wait_r >= period - 32'd1));
   assign busy = (state_r != IDLE);
   assign adc_remote = (state_r == REMOTE);

   // Local then remote, one start pulse per channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= IDLE;
         wait_r <= 32'd0;
         adc_start <= 1'b0;
      end else begin
         adc_start <= 1'b0;
         wait_r <= (go || standby) ? 32'd0 : wait_r + 32'd1;
         case (state_r)
            IDLE: begin
               if (go) begin
                  state_r <= LOCAL;
                  adc_start <= 1'b1;
               end
            end
            LOCAL: begin
               if (adc_done) begin
                  state_r <= REMOTE;
                  adc_start <= 1'b1;
               end
            end
            REMOTE: begin
               if (adc_done) state_r <= IDLE;
            end
            default: state_r <= IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

//--- rtl/tma_filter.sv
// Purpose: Consecutive out-of-limit counter for one limit comparison
// Assumes: sample is a one-cycle pulse per new measurement
// Notes: fire is combinational and valid only with sample
`timescale 1ns/10ps
`default_nettype none
module tma_filter
   import tma_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sample,
   input wire logic out_lim,
   input wire logic [2:0] need,
   output logic fire
);

   logic [2:0] cnt_r;
   logic [2:0] cnt_inc;

   // Saturate at four so a long excursion keeps firing
   assign cnt_inc = (cnt_r == 3'd4) ? cnt_r : cnt_r + 3'd1;
   assign fire = sample && out_lim && (cnt_inc >= need);

   // In-limit result restarts the run
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 3'd0;
      end else if (sample) begin
         cnt_r <= out_lim ? cnt_inc : 3'd0;
      end
   end

endmodule
`default_nettype wire

//--- rtl/tma_top.sv
// Purpose: Register file, limit compare and alarm logic of a two-channel temperature monitor
// Assumes: byte-level serial front end on clk; converter handshake on clk
// Notes: open-drain outputs given as level plus enable; sensor_open_in is async
`timescale 1ns/10ps
`default_nettype none
module tma_top
   import tma_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TMA_TIMEOUT_CYCLES,
   parameter int unsigned CONV_BASE_CYCLES = TMA_FAST_CONV_CYCLES,
   // Arbitrary identity values
   parameter logic [7:0] MAKER_CODE = 8'h5A,
   parameter logic [7:0] REVISION_CODE = 8'h01
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic bus_wr_valid,
   input wire logic bus_wr_first,
   input wire logic [7:0] bus_wr_data,
   input wire logic bus_rd_req,
   output logic [7:0] bus_rd_data,
   output logic bus_rd_valid,
   input wire logic bus_in_frame,
   input wire logic bus_active,
   output logic bus_timeout,
   input wire logic ara_done,
   output logic alert_pending,
   output logic adc_start,
   output logic adc_remote,
   input wire logic adc_done,
   input wire logic [10:0] adc_result,
   input wire logic sensor_open_in,
   output logic alert_n_o,
   output logic alert_n_oe,
   output logic therm_n_o,
   output logic therm_n_oe
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] ptr_r;
   logic wr_armed_r;
   logic [7:0] loc_val_r;
   logic [10:0] rem_val_r;
   logic [7:0] cfg_r;
   logic [7:0] rate_r;
   logic [7:0] loc_hlim_r;
   logic [7:0] loc_llim_r;
   logic [7:0] rem_hlim_hi_r;
   logic [7:0] rem_llim_hi_r;
   logic [7:0] rem_hlim_lo_r;
   logic [7:0] rem_llim_lo_r;
   logic [7:0] off_hi_r;
   logic [7:0] off_lo_r;
   logic [7:0] rem_trip_lim_r;
   logic [7:0] loc_trip_lim_r;
   logic [7:0] hyst_r;
   logic [7:0] filt_r;
   logic [4:0] sticky_r;
   logic [4:0] sticky_nxt;
   logic loc_trip_r;
   logic rem_trip_r;
   logic latch_r;
   logic latch_nxt;
   logic loc_upd_r;
   logic rem_upd_r;
   logic open_s1_r;
   logic open_s2_r;
   logic [31:0] idle_cnt_r;
   logic [7:0] rd_mux;

   // ------------------------------------------------------------
   // Offset add with clamp to the representable range
   // ------------------------------------------------------------
   function automatic logic [10:0] tma_apply_offset(input logic [10:0] raw, input logic [10:0] off);
      logic signed [12:0] sum;
      sum = $signed({2'b00, raw}) + $signed({{2{off[10]}}, off});
      if (sum < 13'sh0000) return 11'h000;
      else if (sum > 13'sh07FF) return 11'h7FF;
      else return sum[10:0];
   endfunction

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic wr_data;
   logic rd_status;
   logic oneshot;
   logic standby;
   logic busy;

   // Data bytes only count after a pointer byte in the same frame
   assign wr_data = bus_wr_valid && !bus_wr_first && wr_armed_r;
   assign rd_status = bus_rd_req && (ptr_r == TMA_RD_STATUS);
   assign oneshot = wr_data && (ptr_r == TMA_WR_ONESHOT);
   assign standby = cfg_r[TMA_CFG_STANDBY];

   function automatic logic wr_hit(input logic [7:0] p, input logic [7:0] a);
      return p == a;
   endfunction

   // ------------------------------------------------------------
   // Conversion scheduling
   // ------------------------------------------------------------
   tma_conv_sched #(
      .BASE_CYCLES(CONV_BASE_CYCLES)
   ) u_sched (
      .clk(clk),
      .rst(rst),
      .standby(standby),
      .oneshot(oneshot),
      .rate_code(rate_r[3:0]),
      .adc_done(adc_done),
      .adc_start(adc_start),
      .adc_remote(adc_remote),
      .busy(busy)
   );

   // Open-sensor level comes from the analog side, so synchronise it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         open_s1_r <= 1'b0;
         open_s2_r <= 1'b0;
      end else begin
         open_s1_r <= sensor_open_in;
         open_s2_r <= open_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Measurement capture
   // ------------------------------------------------------------
   // Only the converter writes these; compare runs one cycle later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loc_val_r <= TMA_RST_ZERO;
         rem_val_r <= 11'h000;
         loc_upd_r <= 1'b0;
         rem_upd_r <= 1'b0;
      end else begin
         loc_upd_r <= adc_done && !adc_remote;
         rem_upd_r <= adc_done && adc_remote;
         if (adc_done && !adc_remote) loc_val_r <= adc_result[10:3];
         if (adc_done && adc_remote) begin
            rem_val_r <= tma_apply_offset(adc_result, {off_hi_r, off_lo_r[7:5]});
         end
      end
   end

   // ------------------------------------------------------------
   // Limit comparisons
   // ------------------------------------------------------------
   logic [10:0] rem_hlim;
   logic [10:0] rem_llim;
   logic loc_over;
   logic loc_under;
   logic rem_over;
   logic rem_under;
   logic [2:0] need;

   assign rem_hlim = {rem_hlim_hi_r, rem_hlim_lo_r[7:5]};
   assign rem_llim = {rem_llim_hi_r, rem_llim_lo_r[7:5]};
   assign loc_over = loc_val_r > loc_hlim_r;
   assign loc_under = loc_val_r < loc_llim_r;
   assign rem_over = rem_val_r > rem_hlim;
   assign rem_under = rem_val_r < rem_llim;
   assign need = tma_filter_need(filt_r[TMA_FLT_CNT_LSB +: 3]);

   // One counter per comparison so runs do not mix
   logic [3:0] fire;
   logic [3:0] smp;
   logic [3:0] lim;
   assign smp = {loc_upd_r, loc_upd_r, rem_upd_r, rem_upd_r};
   assign lim = {loc_over, loc_under, rem_over, rem_under};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_filt
         tma_filter u_filt (
            .clk(clk),
            .rst(rst),
            .sample(smp[gi]),
            .out_lim(lim[gi]),
            .need(need),
            .fire(fire[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Sticky flags and alarm latch
   // ------------------------------------------------------------
   logic [4:0] cause;
   logic [4:0] setv;
   logic [4:0] clrv;

   // Order: local over, local under, remote over, remote under, open
   assign cause = {lim, open_s2_r};
   assign setv = {fire, rem_upd_r && open_s2_r};
   // Read clears only flags whose cause has gone; set wins
   assign clrv = rd_status ? ~cause : 5'b00000;
   assign sticky_nxt = (sticky_r & ~clrv) | setv;

   // Latch releases on address service once cause and flags are gone
   assign latch_nxt = (|sticky_r) || (latch_r && !(ara_done && !(|cause)));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sticky_r <= 5'b00000;
         latch_r <= 1'b0;
      end else begin
         sticky_r <= sticky_nxt;
         latch_r <= latch_nxt;
      end
   end

   // ------------------------------------------------------------
   // Thermal trip with shared hysteresis
   // ------------------------------------------------------------
   logic loc_trip_set;
   logic loc_trip_rel;
   logic rem_trip_set;
   logic rem_trip_rel;

   // Release at or below limit minus hysteresis; 9-bit sum avoids wrap
   assign loc_trip_set = loc_val_r > loc_trip_lim_r;
   assign loc_trip_rel = ({1'b0, loc_val_r} + {1'b0, hyst_r}) <= {1'b0, loc_trip_lim_r};
   assign rem_trip_set = rem_val_r[10:3] > rem_trip_lim_r;
   assign rem_trip_rel = ({1'b0, rem_val_r[10:3]} + {1'b0, hyst_r}) <= {1'b0, rem_trip_lim_r};

   // Clears by itself, no host service needed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loc_trip_r <= 1'b0;
         rem_trip_r <= 1'b0;
      end else begin
         if (loc_upd_r) loc_trip_r <= loc_trip_set || (loc_trip_r && !loc_trip_rel);
         if (rem_upd_r) rem_trip_r <= rem_trip_set || (rem_trip_r && !rem_trip_rel);
      end
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   // Mask hides the pin and alert_pending; the latch still records the event
   assign alert_n_o = 1'b0;
   assign alert_n_oe = latch_r && !cfg_r[TMA_CFG_MASK];
   assign alert_pending = alert_n_oe;
   assign therm_n_o = 1'b0;
   assign therm_n_oe = loc_trip_r || rem_trip_r;

   // ------------------------------------------------------------
   // Bus timeout
   // ------------------------------------------------------------
   logic to_run;
   logic to_hit;
   assign to_run = filt_r[TMA_FLT_TIMEOUT] && bus_in_frame && !bus_active;
   assign to_hit = to_run && (idle_cnt_r >= TIMEOUT_CYCLES - 32'd1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idle_cnt_r <= 32'd0;
         bus_timeout <= 1'b0;
      end else begin
         bus_timeout <= to_hit;
         idle_cnt_r <= (to_run && !to_hit) ? idle_cnt_r + 32'd1 : 32'd0;
      end
   end

   // ------------------------------------------------------------
   // Pointer and register writes
   // ------------------------------------------------------------
   // Abandoned transaction drops its pending data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_r <= TMA_RST_ZERO;
         wr_armed_r <= 1'b0;
      end else begin
         if (bus_wr_valid && bus_wr_first) begin
            ptr_r <= bus_wr_data;
            wr_armed_r <= 1'b1;
         end else if (to_hit || !bus_in_frame) begin
            wr_armed_r <= 1'b0;
         end
      end
   end

   // Unlisted addresses fall through untouched; one-shot stores nothing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r <= TMA_RST_ZERO;
         rate_r <= TMA_RST_RATE;
         loc_hlim_r <= TMA_RST_HLIM;
         loc_llim_r <= TMA_RST_ZERO;
         rem_hlim_hi_r <= TMA_RST_HLIM;
         rem_llim_hi_r <= TMA_RST_ZERO;
         rem_hlim_lo_r <= TMA_RST_ZERO;
         rem_llim_lo_r <= TMA_RST_ZERO;
         off_hi_r <= TMA_RST_ZERO;
         off_lo_r <= TMA_RST_ZERO;
         rem_trip_lim_r <= TMA_RST_TRIP;
         loc_trip_lim_r <= TMA_RST_TRIP;
         hyst_r <= TMA_RST_HYST;
         filt_r <= TMA_RST_FILTER;
      end else if (wr_data) begin
         if (wr_hit(ptr_r, TMA_WR_CONFIG)) cfg_r <= bus_wr_data & 8'hC0;
         if (wr_hit(ptr_r, TMA_WR_RATE)) rate_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_WR_LOC_HLIM)) loc_hlim_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_WR_LOC_LLIM)) loc_llim_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_WR_REM_HLIM_HI)) rem_hlim_hi_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_WR_REM_LLIM_HI)) rem_llim_hi_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_REM_HLIM_LO)) rem_hlim_lo_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_REM_LLIM_LO)) rem_llim_lo_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_OFFSET_HI)) off_hi_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_OFFSET_LO)) off_lo_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_REM_TRIP)) rem_trip_lim_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_LOC_TRIP)) loc_trip_lim_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_HYST)) hyst_r <= bus_wr_data;
         if (wr_hit(ptr_r, TMA_RW_FILTER)) filt_r <= bus_wr_data;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [7:0] status;
   assign status = {busy, sticky_r[4:1], sticky_r[0], rem_trip_r, loc_trip_r};

   // Write-only and unused addresses read as zero
   always_comb begin
      case (ptr_r)
         TMA_RD_LOCAL_VAL: rd_mux = loc_val_r;
         TMA_RD_REMOTE_HI: rd_mux = rem_val_r[10:3];
         TMA_RD_STATUS: rd_mux = status;
         TMA_RD_CONFIG: rd_mux = cfg_r;
         TMA_RD_RATE: rd_mux = rate_r;
         TMA_RD_LOC_HLIM: rd_mux = loc_hlim_r;
         TMA_RD_LOC_LLIM: rd_mux = loc_llim_r;
         TMA_RD_REM_HLIM_HI: rd_mux = rem_hlim_hi_r;
         TMA_RD_REM_LLIM_HI: rd_mux = rem_llim_hi_r;
         TMA_RD_REMOTE_LO: rd_mux = {rem_val_r[2:0], 5'b00000};
         TMA_RW_OFFSET_HI: rd_mux = off_hi_r;
         TMA_RW_OFFSET_LO: rd_mux = off_lo_r;
         TMA_RW_REM_HLIM_LO: rd_mux = rem_hlim_lo_r;
         TMA_RW_REM_LLIM_LO: rd_mux = rem_llim_lo_r;
         TMA_RW_REM_TRIP: rd_mux = rem_trip_lim_r;
         TMA_RW_LOC_TRIP: rd_mux = loc_trip_lim_r;
         TMA_RW_HYST: rd_mux = hyst_r;
         TMA_RW_FILTER: rd_mux = filt_r;
         TMA_RD_MAKER: rd_mux = MAKER_CODE;
         TMA_RD_REVISION: rd_mux = REVISION_CODE;
         default: rd_mux = TMA_RST_ZERO;
      endcase
   end

   // Data captured with the request, before the status clear lands
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_rd_data <= TMA_RST_ZERO;
         bus_rd_valid <= 1'b0;
      end else begin
         bus_rd_valid <= bus_rd_req;
         if (bus_rd_req) bus_rd_data <= rd_mux;
      end
   end

endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the temperature monitor registers and alarms
// Assumes: converter model answers every start
// Notes: shortened scheduler and timeout counts
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst = 1'b1, bus_wr_valid = 1'b0, bus_wr_first = 1'b0, bus_rd_req = 1'b0, ara_done = 1'b0;
   logic bus_rd_valid, alert_pending, adc_start, adc_remote, adc_done, alert_n_oe, therm_n_oe, bus_timeout;
   logic sen_open = 1'b0;
   logic [7:0] bus_wr_data = 8'h00, bus_rd_data, q[$];
   logic [10:0] adc_result, loc = 11'h200, rem = 11'h200;
   logic [31:0] r = 32'h0CF9;
   int error_cnt = 0, n_tests = 0, n_to = 0;
   logic [15:0] dflt[12] = '{16'h0300, 16'h0408, 16'h0555, 16'h0600, 16'h0755, 16'h0800,
      16'h1100, 16'h1955, 16'h2055, 16'h210A, 16'h2201, 16'hFE5A};
   always #10 clk = ~clk;
   tma_top #(.TIMEOUT_CYCLES(20), .CONV_BASE_CYCLES(4)) u_dut (.clk, .rst, .bus_wr_valid, .bus_wr_first,
      .bus_wr_data, .bus_rd_req, .bus_rd_data, .bus_rd_valid, .bus_in_frame(1'b1),
      .bus_active(bus_wr_valid || bus_rd_req), .bus_timeout, .ara_done, .alert_pending, .adc_start,
      .adc_remote, .adc_done, .adc_result, .sensor_open_in(sen_open), .alert_n_o(), .alert_n_oe,
      .therm_n_o(), .therm_n_oe);
   tma_adc_model u_adc (.clk, .adc_start, .loc, .rem, .adc_remote, .adc_done, .adc_result);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // Bus bytes go out just after an edge; an idle cycle separates them
   task automatic put(input logic f, input logic [7:0] d);
      bus_wr_valid = 1'b1; bus_wr_first = f; bus_wr_data = d;
      @(posedge clk) #1 bus_wr_valid = 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(1'b1, a); put(1'b0, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      put(1'b1, a); q.push_back(e); bus_rd_req = 1'b1;
      @(posedge clk) #1 bus_rd_req = 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic shot(input logic [10:0] v);
      loc = v; wr(8'h0F, 8'hA5);
      repeat (20) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Each read answer is matched with the oldest noted expectation
   always @(negedge clk) if (bus_rd_valid === 1'b1) chk(bus_rd_data, q.pop_front());
   // Timeout pulses counted mid-cycle, away from the launching edge
   always @(negedge clk) if (bus_timeout === 1'b1) n_to++;
   initial begin
      #100000 error_cnt++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 12; i++) rd(dflt[i][15:8], dflt[i][7:0]);
      wr(8'h09, 8'hFF); rd(8'h03, 8'hC0);
      wr(8'h09, 8'h40); wr(8'h00, 8'h33); rd(8'h00, 8'h40);
      r = lfsr(r); wr(8'h0A, {5'h00, r[2:0]}); rd(8'h04, {5'h00, r[2:0]});
      wr(8'h0B, 8'h40); shot(11'h200); rd(8'h02, 8'h00);
      shot(11'h208); rd(8'h02, 8'h40); rd(8'h02, 8'h40);
      shot(11'h200); rd(8'h02, 8'h40); rd(8'h02, 8'h00);
      chk({7'h00, alert_n_oe}, 8'h01);
      ara_done = 1'b1;
      @(posedge clk) #1 ara_done = 1'b0;
      @(posedge clk) #1 chk({7'h00, alert_n_oe}, 8'h00);
      shot(11'h2B0); chk({7'h00, therm_n_oe}, 8'h01); rd(8'h02, 8'h41);
      shot(11'h200); chk({7'h00, therm_n_oe}, 8'h00); rd(8'h0F, 8'h00);
      wr(8'h11, 8'h01); shot(11'h200); rd(8'h01, 8'h41);
      sen_open = 1'b1; shot(11'h200); rd(8'h02, 8'h44);
      rd(8'h02, 8'h04);
      sen_open = 1'b0; rd(8'h02, 8'h04); rd(8'h02, 8'h00);
      wr(8'h22, 8'h02); shot(11'h208); rd(8'h02, 8'h00);
      shot(11'h208); rd(8'h02, 8'h40);
      chk({7'h00, alert_n_oe}, 8'h01); wr(8'h09, 8'hC0); chk({7'h00, alert_n_oe}, 8'h00);
      // Idle frame with timeout on: one pulse, then a lone data byte is dropped
      wr(8'h22, 8'h81); repeat (30) @(posedge clk);
      #1 put(1'b0, 8'h00); rd(8'h22, 8'h81); chk(8'(n_to), 8'h01);
      chk(8'(q.size()), 8'h00);
      tally_and_finish;
   end
endmodule
`default_nettype wire

//--- verif/tma_adc_model.sv
// Purpose: Converter stand-in answering each start with one result
// Assumes: one conversion at a time
// Notes: latency alternates short and long
`timescale 1ns/10ps
`default_nettype none
module tma_adc_model (
   input wire logic clk,
   input wire logic adc_start,
   input wire logic [10:0] loc,
   input wire logic [10:0] rem,
   input wire logic adc_remote,
   output logic adc_done = 1'b0,
   output logic [10:0] adc_result
);
   logic [2:0] cnt = 3'h0;
   logic slow = 1'b0;
   // One done pulse per start, after a varying wait
   always @(posedge clk) begin
      adc_done <= cnt == 3'h1;
      if (adc_start) begin
         cnt <= slow ? 3'h4 : 3'h1;
         slow <= !slow;
      end else if (cnt != 3'h0) cnt <= cnt - 3'h1;
   end
   // Result scrambled outside done so stale data is never trusted
   assign adc_result = (adc_remote ? rem : loc) ^ {11{!adc_done}};
endmodule
`default_nettype wire

//--- verif/tma_top_sva.sv
// Purpose: Port-level checks of the temperature monitor block
// Assumes: one clock, async active-high reset
// Notes: bound to tma_top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module tma_top_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic bus_rd_req,
   input wire logic bus_rd_valid,
   input wire logic [7:0] bus_rd_data,
   input wire logic bus_wr_valid,
   input wire logic ara_done,
   input wire logic alert_pending,
   input wire logic alert_n_o,
   input wire logic alert_n_oe,
   input wire logic therm_n_o,
   input wire logic adc_start,
   input wire logic adc_remote,
   input wire logic adc_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Conversion order: local result, then remote start
   sequence s_loc_done; adc_done && !adc_remote; endsequence
   sequence s_rem_start; adc_start && adc_remote; endsequence
   a_rd_answer: assert property (bus_rd_req |=> bus_rd_valid) else $error("read not answered");
   a_rd_cause: assert property (bus_rd_valid |-> $past(bus_rd_req)) else $error("stray read answer");
   a_rd_hold: assert property (!bus_rd_valid |-> $stable(bus_rd_data)) else $error("read data moved");
   a_conv_order: assert property (s_loc_done |=> s_rem_start) else $error("remote not started");
   a_start_pulse: assert property (adc_start |=> !adc_start) else $error("start too long");
   a_alert_hold: assert property (alert_n_oe && !ara_done && !bus_wr_valid |=> alert_n_oe)
      else $error("alarm dropped unserviced");
   a_ara_mirror: assert property (alert_pending == alert_n_oe) else $error("ARA answer mismatch");
   a_pins_low: assert property (!alert_n_o && !therm_n_o) else $error("open-drain data high");
endmodule
bind tma_top tma_top_sva u_sva (.clk, .rst, .bus_rd_req, .bus_rd_valid, .bus_rd_data, .bus_wr_valid,
   .ara_done, .alert_pending, .alert_n_o, .alert_n_oe, .therm_n_o, .adc_start, .adc_remote, .adc_done);
`default_nettype wire
